// ===== scsp_clock_select.sv
// system clock source selection with direct drive, pll, wakeup and output prescaler
// assumes every clock source and config input is already synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "scsp_params.svh"

module scsp_clock_select
	import scsp_pkg::*;
(
	input  wire logic               clk,                     // core clock 50 MHz
	input  wire logic               rstn,                    // async reset, active low
	input  wire logic [1:0]         sys_clock_source_select, // source select field
	input  wire logic               vco_bypass_bit,          // 1 = prescaler, 0 = pll
	input  wire scsp_pkg::scsp_div_t output_prescaler_divider, // factor minus one
	input  wire logic               osc_use_internal,        // 1 = internal source
	input  wire logic               direct_clock_input,      // direct drive pin level
	input  wire logic               crystal_input,           // crystal oscillator level
	input  wire logic               internal_clock_input,    // internal source level
	input  wire logic               wakeup_clock_input,      // wakeup source level
	input  wire logic               pll_clock_input,         // pll output level
	output logic                    pll_enable,              // pll requested
	output scsp_pkg::scsp_factor_t  output_prescaler_factor, // active factor
	output logic                    sys_clock_out            // generated system clock
);
	import scsp_pkg::*;

	scsp_mode_t   cfg_mode;
	scsp_mode_t   act_mode;
	scsp_mode_t   next_act_mode;
	scsp_div_t    act_div;
	scsp_div_t    next_act_div;
	scsp_sw_t     sw_state;
	scsp_sw_t     next_sw_state;
	scsp_factor_t cnt;
	scsp_factor_t next_cnt;
	scsp_factor_t factor;
	scsp_factor_t hi_len;
	logic         osc_q;
	logic         next_osc_q;
	logic         osc_now;
	logic         osc_rise;
	logic         changed;
	logic         raw;
	logic         next_out;
	logic         load;

	always_comb
	begin
		if (sys_clock_source_select == `SCSP_SEL_DIRECT)
			cfg_mode = SCSP_MODE_DIRECT;
		else if (sys_clock_source_select == `SCSP_SEL_WAKEUP)
			cfg_mode = SCSP_MODE_WAKEUP;
		else if (sys_clock_source_select == `SCSP_SEL_PLL_PRESC)
			cfg_mode = vco_bypass_bit ? SCSP_MODE_PRESC : SCSP_MODE_PLL;
		else
			cfg_mode = SCSP_MODE_OFF; // unused code holds the clock low
	end

	assign factor = {1'b0, act_div} + 11'h001;
	assign hi_len = factor - (factor >> 1);
	assign osc_now = osc_use_internal ? internal_clock_input : crystal_input;
	// a false rise right after reset only moves the counter, and every switch reloads it
	assign osc_rise = osc_now & ~osc_q;
	// a new divider only matters while the prescaler is the chosen source
	assign changed = (cfg_mode != act_mode) ||
		((cfg_mode == SCSP_MODE_PRESC) && (output_prescaler_divider != act_div));
	assign load = (sw_state == SCSP_SW_DRAIN) && !sys_clock_out;
	assign pll_enable = (cfg_mode == SCSP_MODE_PLL) || (act_mode == SCSP_MODE_PLL);
	assign output_prescaler_factor = factor;

	always_comb
	begin
		next_osc_q = osc_now;
		next_cnt = cnt;
		if ((act_mode == SCSP_MODE_PRESC) && osc_rise)
			next_cnt = (cnt == factor - 11'h001) ? 11'h000 : cnt + 11'h001;
		case (act_mode)
			SCSP_MODE_DIRECT: raw = direct_clock_input;
			SCSP_MODE_WAKEUP: raw = wakeup_clock_input;
			SCSP_MODE_PLL:    raw = pll_clock_input;
			SCSP_MODE_PRESC:  raw = (act_div == `SCSP_DIV_RESET) ? osc_now : (next_cnt < hi_len);
			default:          raw = 1'b0;
		endcase
		next_act_mode = act_mode;
		next_act_div = act_div;
		next_sw_state = sw_state;
		next_out = raw;
		case (sw_state)
			SCSP_SW_RUN:
			begin
				if (changed)
					next_sw_state = SCSP_SW_DRAIN;
			end
			SCSP_SW_DRAIN:
			begin
				// keep the running clock until it falls on its own, so no high pulse is cut
				if (load)
				begin
					next_act_mode = cfg_mode;
					next_act_div = output_prescaler_divider;
					next_cnt = {1'b0, output_prescaler_divider}; // first edge lands on zero
					next_out = 1'b0;
					next_sw_state = SCSP_SW_RUN;
				end
			end
			default: next_sw_state = SCSP_SW_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			act_mode <= SCSP_MODE_WAKEUP;
			act_div <= `SCSP_DIV_RESET;
			sw_state <= SCSP_SW_RUN;
			cnt <= 11'h000;
			osc_q <= 1'b0;
			sys_clock_out <= 1'b0;
		end
		else
		begin
			act_mode <= next_act_mode;
			act_div <= next_act_div;
			sw_state <= next_sw_state;
			cnt <= next_cnt;
			osc_q <= next_osc_q;
			sys_clock_out <= next_out;
		end
	end

	logic steady;
	assign steady = (sw_state == SCSP_SW_RUN) && !changed;

	// source rises seen while the divided clock is high; a cut high phase shows a short count
	scsp_factor_t hi_rises;
	scsp_factor_t next_hi_rises;

	always_comb
	begin
		next_hi_rises = hi_rises;
		if (!sys_clock_out)
			next_hi_rises = 11'h000;
		else if (osc_rise)
			next_hi_rises = hi_rises + 11'h001;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			hi_rises <= 11'h000;
		else
			hi_rises <= next_hi_rises;
	end

	a_direct_follow: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode == SCSP_MODE_DIRECT |=> sys_clock_out == $past(direct_clock_input))
		else $error("direct drive does not follow input");
	a_wakeup_follow: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode == SCSP_MODE_WAKEUP |=> sys_clock_out == $past(wakeup_clock_input))
		else $error("wakeup mode does not follow wakeup clock");
	a_pll_follow: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode == SCSP_MODE_PLL |=> sys_clock_out == $past(pll_clock_input)
		&& pll_enable)
		else $error("pll mode output wrong");
	a_presc_mode: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode == SCSP_MODE_PRESC && act_div == 10'h000 && osc_use_internal
		|=> sys_clock_out == $past(internal_clock_input))
		else $error("prescaler does not take the internal source");
	a_factor_value: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode == SCSP_MODE_PRESC
		|-> output_prescaler_factor == {1'b0, output_prescaler_divider} + 11'h001)
		else $error("factor is not divider plus one");
	a_pass_through: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode == SCSP_MODE_PRESC && act_div == 10'h000 && !osc_use_internal
		|=> sys_clock_out == $past(crystal_input))
		else $error("factor one does not pass crystal through");
	a_cnt_bound: assert property (@(posedge clk) disable iff (!rstn)
		act_mode == SCSP_MODE_PRESC |-> cnt < factor && factor <= `SCSP_MAX_FACTOR)
		else $error("prescaler count beyond 1024");
	a_rise_at_zero: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode == SCSP_MODE_PRESC && act_div != 10'h000 && $rose(sys_clock_out)
		|-> cnt == 11'h000 && $past(osc_rise))
		else $error("divided clock rose off its count");
	a_switch_low: assert property (@(posedge clk) disable iff (!rstn)
		sw_state == SCSP_SW_DRAIN && sys_clock_out |=> sw_state == SCSP_SW_DRAIN)
		else $error("source switched while clock high");
	a_no_runt: assert property (@(posedge clk) disable iff (!rstn)
		$changed(act_mode) || $changed(act_div) |-> !sys_clock_out && !$past(sys_clock_out))
		else $error("source changed around a high output");
	a_full_high: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode == SCSP_MODE_PRESC && act_div != 10'h000 && $fell(sys_clock_out)
		|-> hi_rises == ({1'b0, act_div} + 11'h002) >> 1)
		else $error("divided clock high phase cut short");
	a_presc_hold: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode == SCSP_MODE_PRESC && act_div != 10'h000 && !osc_rise
		|=> sys_clock_out == $past(sys_clock_out))
		else $error("divided clock moved without a source rise");
	a_pll_idle: assert property (@(posedge clk) disable iff (!rstn)
		steady && act_mode != SCSP_MODE_PLL |-> !pll_enable)
		else $error("pll enabled outside pll mode");

	c_direct: cover property (@(posedge clk) disable iff (!rstn)
		act_mode == SCSP_MODE_DIRECT && $rose(sys_clock_out));
	c_presc_max: cover property (@(posedge clk) disable iff (!rstn)
		act_mode == SCSP_MODE_PRESC && act_div == 10'h3FF && $rose(sys_clock_out));
	c_switch: cover property (@(posedge clk) disable iff (!rstn)
		sw_state == SCSP_SW_DRAIN ##1 sw_state == SCSP_SW_RUN);
	c_pll: cover property (@(posedge clk) disable iff (!rstn)
		act_mode == SCSP_MODE_PLL && $rose(sys_clock_out));
	c_pass_internal: cover property (@(posedge clk) disable iff (!rstn)
		act_mode == SCSP_MODE_PRESC && act_div == 10'h000 && osc_use_internal
		&& $rose(sys_clock_out));
endmodule
`default_nettype wire

// ===== scsp_params.svh
// constants for the system clock source and prescaler block
// assumes a single 50 MHz core clock; all clock sources arrive as sampled levels
`ifndef SCSP_PARAMS_SVH
`define SCSP_PARAMS_SVH

`define SCSP_SEL_WAKEUP 2'h0
`define SCSP_SEL_PLL_PRESC 2'h2
`define SCSP_SEL_DIRECT 2'h3
`define SCSP_DIV_W 10
`define SCSP_FACTOR_W 11
`define SCSP_MAX_FACTOR 11'h400
`define SCSP_DIV_RESET 10'h000
`define SCSP_SEL_RESET 2'h0

`endif

// ===== scsp_pkg.sv
// types for the system clock source and prescaler block
// assumes scsp_params.svh supplies the numeric constants
`include "scsp_params.svh"

package scsp_pkg;
	typedef enum logic [2:0] {
		SCSP_MODE_OFF,
		SCSP_MODE_WAKEUP,
		SCSP_MODE_PLL,
		SCSP_MODE_PRESC,
		SCSP_MODE_DIRECT
	} scsp_mode_t;

	typedef enum logic {
		SCSP_SW_RUN,
		SCSP_SW_DRAIN
	} scsp_sw_t;

	typedef logic [`SCSP_DIV_W-1:0] scsp_div_t;
	typedef logic [`SCSP_FACTOR_W-1:0] scsp_factor_t;
endpackage

// ===== scsp_clock_select_bench.sv
// bench for scsp_clock_select: queued expectations for the following modes, run lengths
// for the prescaler; assumes 50 MHz clk and source levels driven on the falling edge
`timescale 1ns/10ps
`default_nettype none
module scsp_clock_select_bench;
	import scsp_pkg::*;
	logic         clk, rstn, byp, use_int, pll_en, out;
	logic [1:0]   sel;
	logic [4:0]   src; // direct, crystal, internal, wakeup, pll
	logic [3:0]   ph;
	scsp_div_t    div;
	scsp_factor_t fac;
	int           n_fail, tests_run, seed, pick, mode, hi, lo;
	logic         exp_q[$];

	scsp_clock_select i_dut (.clk(clk), .rstn(rstn), .sys_clock_source_select(sel),
		.vco_bypass_bit(byp), .output_prescaler_divider(div), .osc_use_internal(use_int),
		.direct_clock_input(src[0]), .crystal_input(src[1]), .internal_clock_input(src[2]),
		.wakeup_clock_input(src[3]), .pll_clock_input(src[4]), .pll_enable(pll_en),
		.output_prescaler_factor(fac), .sys_clock_out(out));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic check(input logic [11:0] seen, input logic [11:0] expd);
		tests_run++;
		if (seen !== expd)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expd);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// mode 0 parks sources low so a switch never waits on a running clock
	always @(negedge clk)
	begin
		if (mode == 1)
		begin
			src = 5'($random(seed));
			exp_q.push_back((pick < 5) ? src[pick] : 1'b0);
		end
		else if (mode == 2)
		begin
			ph = ph + 4'h1;
			src = {5{ph[1]}};
		end
		else
			src = 5'h00;
	end

	always @(posedge clk)
	begin
		#1;
		if (exp_q.size() > 0)
			check(12'(out), 12'(exp_q.pop_front()));
	end

	task automatic setup(input logic [1:0] s, input logic b, u, input scsp_div_t d,
		input int p, f);
		@(posedge clk) mode = f ? 0 : 2;
		repeat (2) @(negedge clk);
		sel = s;
		byp = b;
		use_int = u;
		div = d;
		pick = p;
		repeat (12) @(negedge clk);
		check(12'(fac), 12'(d) + 12'h001);
		check(12'(pll_en), 12'((s == 2'h2) && !b));
		if (f)
		begin
			@(posedge clk) mode = 1;
			repeat (30) @(posedge clk);
		end
	endtask

	task automatic span(input logic v, output int n);
		n = 0;
		while (out === v && n < 5000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	// source period is 4 clk; first two spans only align to a fresh high phase
	task automatic measure(input int k);
		span(1'b1, hi);
		span(1'b0, lo);
		span(1'b1, hi);
		span(1'b0, lo);
		check(12'(hi), 12'(4 * ((k + 1) / 2)));
		check(12'(lo), 12'(4 * (k / 2)));
	endtask

	initial
	begin
		rstn = 1'b0;
		sel = 2'h0;
		byp = 1'b0;
		use_int = 1'b0;
		div = 10'h000;
		src = 5'h00;
		mode = 0;
		pick = 5;
		ph = 4'h0;
		seed = 55089;
		n_fail = 0;
		tests_run = 0;
		repeat (5) @(negedge clk);
		check(12'(out), 12'h000);
		check(12'(fac), 12'h001);
		rstn = 1'b1;
		setup(2'h1, 0, 0, 10'($random(seed)), 5, 1);
		setup(2'h0, 1, 0, 10'($random(seed)), 3, 1);
		setup(2'h3, 1, 1, 10'($random(seed)), 0, 1);
		setup(2'h2, 0, 0, 10'($random(seed)), 4, 1);
		setup(2'h2, 1, 0, 10'h000, 1, 1);
		setup(2'h2, 1, 1, 10'h000, 2, 1);
		setup(2'h2, 1, 0, 10'h002, 5, 0);
		measure(3);
		setup(2'h2, 1, 1, 10'h3FF, 5, 0);
		measure(1024);
		print_verdict;
	end

	initial
	begin
		#600000;
		n_fail++;
		print_verdict;
	end
endmodule
`default_nettype wire
